// ### verilog/eda_defs.vh
`ifndef EDA_DEFS_VH
`define EDA_DEFS_VH

// ****************************************************************
// encoder configuration bit positions
// ****************************************************************
`define EDA_CFG_IDX_POL 0
`define EDA_CFG_IDX_CLR 1
`define EDA_CFG_LOAD_RAMP 4
`define EDA_CFG_DIR_AB 6

// ****************************************************************
// widths
// ****************************************************************
`define EDA_CNT_W 24
`define EDA_DEV_W 11
`define EDA_TOL_W 16
`define EDA_DLY_W 16

// ****************************************************************
// stop actions and power policy
// ****************************************************************
`define EDA_STOP_NONE 2'h0
`define EDA_STOP_SOFT 2'h1
`define EDA_STOP_HARD 2'h2
`define EDA_POLICY_POWER_OFF 1'b1

// ****************************************************************
// timing: correction delay tick is 1/200 s = 5000000 ns
// ****************************************************************
`define EDA_TICK_NS 5000000
`define EDA_CLK_NS 4
`define EDA_TICK_CYCLES (`EDA_TICK_NS / `EDA_CLK_NS)

// ****************************************************************
// alarm reply cause bit order (bit 4 driver .. bit 0 correction)
// ****************************************************************
`define EDA_CAUSE_DRV 4
`define EDA_CAUSE_DEV 3
`define EDA_CAUSE_EXT 2
`define EDA_CAUSE_TRV 1
`define EDA_CAUSE_POS 0

`endif

// ### verilog/eda_encoder_alarm.v
// Notes on behaviour
// - config bit 0 picks index polarity
// - bit 1 clears counter on index
// - bit 4 loads ramp position, self-clears
// - bit 6 picks quadrature positive direction
// - pre-divider counts every k-th pulse
// - multiplier steps counter by m
// - deviation threshold is unsigned 11 bits
// - query returns signed 24-bit counter
// - enabled alarm when deviation exceeds threshold
// - stop action: none, soft, hard
// - correction delay n/200 s, zero disables
// - correction holds alarm until retries spent
// - end of ramp tolerance check
// - end tolerance is unsigned 16 bits
// - correct toward target at search velocity
// - retries zero off, 1-255 attempts
// - retries exceeded: abandon, alarm, record
// - regulator enable off at 0, on 1
// - external alarm stops, optional power off
// - driver error policy stops and unpowers
// - alarm reset clears, reports five causes
`include "eda_defs.vh"

module eda_encoder_alarm #(
  parameter TICK_CYCLES = `EDA_TICK_CYCLES
) (
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire enc_a_i,
  input wire enc_b_i,
  input wire enc_n_i,
  input wire cfg_we_i,
  input wire [7:0] cfg_bits_i,
  input wire [7:0] cfg_prediv_i,
  input wire [`EDA_DEV_W-1:0] cfg_max_dev_i,
  input wire [7:0] cfg_mult_i,
  input wire dev_cfg_we_i,
  input wire dev_en_i,
  input wire [1:0] dev_stop_i,
  input wire [`EDA_DLY_W-1:0] dev_delay_i,
  input wire cor_cfg_we_i,
  input wire [7:0] cor_retries_i,
  input wire [`EDA_TOL_W-1:0] cor_tol_i,
  input wire reg_cmd_we_i,
  input wire reg_cmd_val_i,
  input wire pol_we_i,
  input wire pol_ext_i,
  input wire pol_drv_i,
  input wire [`EDA_CNT_W-1:0] ramp_pos_i,
  input wire [`EDA_CNT_W-1:0] target_pos_i,
  input wire ramp_end_i,
  input wire ext_alarm_i,
  input wire drv_err_i,
  input wire travel_err_i,
  input wire query_i,
  input wire alarm_reset_i,
  output reg [`EDA_CNT_W-1:0] enc_count_o,
  output reg query_valid_o,
  output reg [31:0] query_data_o,
  output reg reset_valid_o,
  output reg [4:0] reset_causes_o,
  output reg alarm_o,
  output reg soft_stop_o,
  output reg hard_stop_o,
  output reg power_off_o,
  output reg reg_en_o,
  output reg cor_move_o,
  output reg [`EDA_CNT_W-1:0] cor_target_o,
  output reg [7:0] cfg_bits_o
);

  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  reg rst_meta_reg;
  reg rst_n_reg;
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // distance between two positions
  // ****************************************************************
  function [`EDA_CNT_W-1:0] abs_diff;
    input [`EDA_CNT_W-1:0] a;
    input [`EDA_CNT_W-1:0] b;
    reg [`EDA_CNT_W-1:0] d;
    begin
      d = a - b;
      abs_diff = d[`EDA_CNT_W-1] ? (~d + 24'h00_0001) : d;
    end
  endfunction

  // ****************************************************************
  // correction states
  // ****************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_MOVE = 2'h2;

  // ****************************************************************
  // configuration state
  // ****************************************************************
  reg [7:0] prediv_reg;
  reg [7:0] mult_reg;
  reg [`EDA_DEV_W-1:0] max_dev_reg;
  reg dev_en_reg;
  reg [1:0] stop_act_reg;
  reg [`EDA_DLY_W-1:0] delay_reg;
  reg [7:0] retries_reg;
  reg [`EDA_TOL_W-1:0] tol_reg;
  reg pol_ext_reg;
  reg pol_drv_reg;

  // ****************************************************************
  // encoder decode
  // ****************************************************************
  reg a_reg;
  reg b_reg;
  reg n_reg;
  reg [7:0] div_cnt_reg;
  wire a_edge = enc_a_i ^ a_reg;
  wire b_edge = enc_b_i ^ b_reg;
  wire pulse = a_edge ^ b_edge;
  // a leads b when the changed channel makes a!=b after a edge ... standard x4 decode
  wire dir_ab = a_edge ? (enc_a_i ^ enc_b_i) : ~(enc_a_i ^ enc_b_i);
  wire up = cfg_bits_o[`EDA_CFG_DIR_AB] ? dir_ab : ~dir_ab;
  wire n_act = cfg_bits_o[`EDA_CFG_IDX_POL] ? enc_n_i : ~enc_n_i;
  wire n_prev = cfg_bits_o[`EDA_CFG_IDX_POL] ? n_reg : ~n_reg;
  wire n_rise = n_act & ~n_prev;
  wire div_hit = (prediv_reg <= 8'h01) || (div_cnt_reg + 8'h01 >= prediv_reg);
  wire [`EDA_CNT_W-1:0] step = (mult_reg == 8'h00) ? 24'h00_0001 : {16'h0000, mult_reg};

  // ****************************************************************
  // deviation and correction
  // ****************************************************************
  reg [1:0] state_reg;
  reg [31:0] tick_reg;
  reg [`EDA_DLY_W-1:0] dly_cnt_reg;
  reg [7:0] tries_reg;
  reg [4:0] cause_reg;
  wire dev_over = abs_diff(ramp_pos_i, enc_count_o) > {13'h0000, max_dev_reg};
  wire dev_evt = dev_en_reg && dev_over;
  wire end_bad = abs_diff(target_pos_i, enc_count_o) > {8'h00, tol_reg};
  wire cor_on = retries_reg != 8'h00;
  wire dly_on = delay_reg != 16'h0000;

  // ****************************************************************
  // events that must survive a same-cycle alarm reset
  // ****************************************************************
  wire dev_fire = (state_reg == ST_IDLE) && dev_evt && !cause_reg[`EDA_CAUSE_DEV];
  wire dev_alarm = dev_fire && !(dly_on && cor_on);
  wire pos_fire = (state_reg == ST_MOVE) && end_bad && (tries_reg >= retries_reg);
  wire ext_off = ext_alarm_i && (pol_ext_reg == `EDA_POLICY_POWER_OFF);
  wire drv_off = drv_err_i && (pol_drv_reg == `EDA_POLICY_POWER_OFF);
  wire [4:0] cause_set = {drv_err_i, dev_fire, ext_alarm_i, travel_err_i, pos_fire};
  wire alarm_set = ext_alarm_i || drv_err_i || travel_err_i || pos_fire || dev_alarm;

  // ****************************************************************
  // counter, alarm policy and correction registers
  // ****************************************************************
  always @(posedge ref_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      n_reg <= 1'b0;
      div_cnt_reg <= 8'h00;
      enc_count_o <= 24'h00_0000;
      cfg_bits_o <= 8'h01;
      prediv_reg <= 8'h01;
      mult_reg <= 8'h01;
      max_dev_reg <= 11'h000;
      dev_en_reg <= 1'b0;
      stop_act_reg <= `EDA_STOP_NONE;
      delay_reg <= 16'h0000;
      retries_reg <= 8'h00;
      tol_reg <= 16'h0000;
      pol_ext_reg <= 1'b0;
      pol_drv_reg <= 1'b0;
      reg_en_o <= 1'b0;
      query_valid_o <= 1'b0;
      query_data_o <= 32'h0000_0000;
      reset_valid_o <= 1'b0;
      reset_causes_o <= 5'h00;
      alarm_o <= 1'b0;
      soft_stop_o <= 1'b0;
      hard_stop_o <= 1'b0;
      power_off_o <= 1'b0;
      cor_move_o <= 1'b0;
      cor_target_o <= 24'h00_0000;
      state_reg <= ST_IDLE;
      tick_reg <= 32'h0000_0000;
      dly_cnt_reg <= 16'h0000;
      tries_reg <= 8'h00;
      cause_reg <= 5'h00;
    end else begin
      a_reg <= enc_a_i;
      b_reg <= enc_b_i;
      n_reg <= enc_n_i;
      soft_stop_o <= 1'b0;
      hard_stop_o <= 1'b0;
      cor_move_o <= 1'b0;
      query_valid_o <= 1'b0;
      reset_valid_o <= 1'b0;
      // configuration writes; reserved bits 2,3,5,7 kept as written by host
      if (cfg_we_i) begin
        cfg_bits_o <= cfg_bits_i;
        prediv_reg <= cfg_prediv_i;
        max_dev_reg <= cfg_max_dev_i;
        mult_reg <= cfg_mult_i;
      end
      if (dev_cfg_we_i) begin
        dev_en_reg <= dev_en_i;
        stop_act_reg <= dev_stop_i;
        delay_reg <= dev_delay_i;
      end
      if (cor_cfg_we_i) begin
        retries_reg <= cor_retries_i;
        tol_reg <= cor_tol_i;
      end
      if (reg_cmd_we_i) begin
        reg_en_o <= reg_cmd_val_i;
      end
      if (pol_we_i) begin
        pol_ext_reg <= pol_ext_i;
        pol_drv_reg <= pol_drv_i;
      end
      // ****************************************************************
      // counter
      // ****************************************************************
      if (cfg_bits_o[`EDA_CFG_LOAD_RAMP]) begin
        enc_count_o <= ramp_pos_i;
        cfg_bits_o[`EDA_CFG_LOAD_RAMP] <= 1'b0;
      end else if (cfg_bits_o[`EDA_CFG_IDX_CLR] && n_rise) begin
        enc_count_o <= 24'h00_0000;
      end else if (pulse) begin
        if (div_hit) begin
          div_cnt_reg <= 8'h00;
          enc_count_o <= up ? enc_count_o + step : enc_count_o - step;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
      if (query_i) begin
        query_valid_o <= 1'b1;
        query_data_o <= {8'h00, enc_count_o};
      end
      // ****************************************************************
      // alarm policy
      // ****************************************************************
      if (ext_alarm_i) begin
        cause_reg[`EDA_CAUSE_EXT] <= 1'b1;
        alarm_o <= 1'b1;
        hard_stop_o <= 1'b1;
        if (pol_ext_reg == `EDA_POLICY_POWER_OFF) begin
          power_off_o <= 1'b1;
        end
      end
      if (drv_err_i) begin
        cause_reg[`EDA_CAUSE_DRV] <= 1'b1;
        alarm_o <= 1'b1;
        if (pol_drv_reg == `EDA_POLICY_POWER_OFF) begin
          hard_stop_o <= 1'b1;
          power_off_o <= 1'b1;
        end
      end
      if (travel_err_i) begin
        cause_reg[`EDA_CAUSE_TRV] <= 1'b1;
        alarm_o <= 1'b1;
      end
      // deviation and correction machine
      case (state_reg)
        ST_IDLE: begin
          tick_reg <= 32'h0000_0000;
          dly_cnt_reg <= 16'h0000;
          if (dev_evt && !cause_reg[`EDA_CAUSE_DEV]) begin
            cause_reg[`EDA_CAUSE_DEV] <= 1'b1;
            if (stop_act_reg == `EDA_STOP_SOFT) begin
              soft_stop_o <= 1'b1;
            end else if (stop_act_reg == `EDA_STOP_HARD) begin
              hard_stop_o <= 1'b1;
            end
            if (dly_on && cor_on) begin
              tries_reg <= 8'h00;
              state_reg <= ST_WAIT;
            end else begin
              alarm_o <= 1'b1;
            end
          end else if (ramp_end_i && cor_on) begin
            tries_reg <= 8'h00;
            state_reg <= ST_MOVE;
          end
        end
        ST_WAIT: begin
          if (tick_reg >= TICK_CYCLES - 1) begin
            tick_reg <= 32'h0000_0000;
            if (dly_cnt_reg + 16'h0001 >= delay_reg) begin
              state_reg <= ST_MOVE;
            end else begin
              dly_cnt_reg <= dly_cnt_reg + 16'h0001;
            end
          end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
          end
        end
        ST_MOVE: begin
          if (!end_bad) begin
            state_reg <= ST_IDLE;
          end else if (tries_reg >= retries_reg) begin
            cause_reg[`EDA_CAUSE_POS] <= 1'b1;
            alarm_o <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (ramp_end_i || tries_reg == 8'h00) begin
            tries_reg <= tries_reg + 8'h01;
            cor_move_o <= 1'b1;
            cor_target_o <= target_pos_i;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // ****************************************************************
      // alarm reset comes last; a same-cycle event still sets its cause
      // ****************************************************************
      if (alarm_reset_i) begin
        reset_valid_o <= 1'b1;
        reset_causes_o <= cause_reg;
        alarm_o <= alarm_set;
        power_off_o <= ext_off || drv_off;
        cause_reg <= cause_set;
      end
    end
  end

endmodule

// ### verif/eda_encoder_alarm_monitor.sv
// ****
// port checker
// ****
module eda_encoder_alarm_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_bits_i,
  input wire logic [23:0] ramp_pos_i,
  input wire logic [23:0] target_pos_i,
  input wire logic ramp_end_i,
  input wire logic ext_alarm_i,
  input wire logic drv_err_i,
  input wire logic travel_err_i,
  input wire logic query_i,
  input wire logic alarm_reset_i,
  input wire logic reg_cmd_we_i,
  input wire logic reg_cmd_val_i,
  input wire logic [23:0] enc_count_o,
  input wire logic query_valid_o,
  input wire logic [31:0] query_data_o,
  input wire logic reset_valid_o,
  input wire logic alarm_o,
  input wire logic reg_en_o,
  input wire logic [7:0] cfg_bits_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_ask; query_i; endsequence
  sequence s_ans; ##1 query_valid_o && query_data_o[31:24] == 8'h00; endsequence
  property p_query; s_ask |-> s_ans; endproperty
  a_query: assert property (p_query) else $error("query answer wrong");
  property p_lone; query_valid_o |-> $past(query_i); endproperty
  a_lone: assert property (p_lone) else $error("unasked query answer");
  sequence s_load_req; cfg_we_i && cfg_bits_i[4]; endsequence
  sequence s_load_done;
    ##1 cfg_bits_o[4] ##1 enc_count_o == $past(ramp_pos_i) && !cfg_bits_o[4];
  endsequence
  property p_load; s_load_req |-> s_load_done; endproperty
  a_load: assert property (p_load) else $error("ramp load wrong");
  property p_ext; ext_alarm_i |=> alarm_o; endproperty
  a_ext: assert property (p_ext) else $error("external alarm missed");
  property p_err; drv_err_i || travel_err_i |=> alarm_o; endproperty
  a_err: assert property (p_err) else $error("error alarm missed");
  property p_hold; alarm_o && !alarm_reset_i |=> alarm_o; endproperty
  a_hold: assert property (p_hold) else $error("alarm dropped");
  property p_clear;
    alarm_reset_i && !(ext_alarm_i || drv_err_i || travel_err_i || ramp_end_i)
      && ramp_pos_i == enc_count_o && target_pos_i == enc_count_o
      |=> !alarm_o && reset_valid_o;
  endproperty
  a_clear: assert property (p_clear) else $error("alarm reset failed");
  property p_reg; reg_cmd_we_i |=> reg_en_o == $past(reg_cmd_val_i); endproperty
  a_reg: assert property (p_reg) else $error("regulator enable wrong");
endmodule
bind eda_encoder_alarm eda_encoder_alarm_monitor mon_u (.ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i), .cfg_we_i(cfg_we_i), .cfg_bits_i(cfg_bits_i), .ramp_pos_i(ramp_pos_i),
  .target_pos_i(target_pos_i), .ramp_end_i(ramp_end_i), .ext_alarm_i(ext_alarm_i),
  .drv_err_i(drv_err_i), .travel_err_i(travel_err_i), .query_i(query_i),
  .alarm_reset_i(alarm_reset_i), .reg_cmd_we_i(reg_cmd_we_i), .reg_cmd_val_i(reg_cmd_val_i),
  .enc_count_o(enc_count_o), .query_valid_o(query_valid_o), .query_data_o(query_data_o),
  .reset_valid_o(reset_valid_o), .alarm_o(alarm_o), .reg_en_o(reg_en_o),
  .cfg_bits_o(cfg_bits_o));

// ### verif/eda_host_model.sv
// ****
// host and encoder model
// ****
module eda_host_model (
  input wire logic ref_clk_i,
  output logic enc_a_o = 1'b0,
  output logic enc_b_o = 1'b0,
  output logic enc_n_o = 1'b0,
  output logic cfg_we_o = 1'b0,
  output logic [7:0] cfg_bits_o = 8'h00,
  output logic [7:0] cfg_prediv_o = 8'h00,
  output logic [10:0] cfg_max_dev_o = 11'h000,
  output logic [7:0] cfg_mult_o = 8'h01
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph = 0;
  task step(input bit up, input int n);
    repeat (n) begin
      repeat (2) @(posedge ref_clk_i);
      ph = up ? ph + 1 : ph + 3;
      enc_a_o <= ph[1] ^ ph[0];
      enc_b_o <= ph[1];
    end
  endtask
  task index(input bit lv);
    @(posedge ref_clk_i);
    enc_n_o <= lv;
  endtask
  task cfg(input logic [7:0] b, input logic [7:0] k, input logic [10:0] d, input logic [7:0] m);
    @(posedge ref_clk_i);
    cfg_we_o <= 1'b1;
    cfg_bits_o <= b & 8'h53;
    cfg_prediv_o <= k;
    cfg_max_dev_o <= d;
    cfg_mult_o <= m;
    @(posedge ref_clk_i);
    cfg_we_o <= 1'b0;
  endtask
endmodule

// ### verif/eda_encoder_alarm_bench.sv
// ****
// bench
// ****
module eda_encoder_alarm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, arst_n_i = 0, dev_cfg_we_i = 0, dev_en_i = 0, cor_cfg_we_i = 0;
  logic reg_cmd_we_i = 0, reg_cmd_val_i = 0, pol_we_i = 0, pol_ext_i = 0, pol_drv_i = 0;
  logic ramp_end_i = 0, ext_alarm_i = 0, drv_err_i = 0, travel_err_i = 0;
  logic query_i = 0, alarm_reset_i = 0;
  logic [1:0] dev_stop_i = 0;
  logic [15:0] dev_delay_i = 0, cor_tol_i = 0;
  logic [7:0] cor_retries_i = 0;
  logic [23:0] ramp_pos_i = 0, target_pos_i = 0;
  wire logic enc_a_i, enc_b_i, enc_n_i, cfg_we_i;
  wire logic [7:0] cfg_bits_i, cfg_prediv_i, cfg_mult_i;
  wire logic [10:0] cfg_max_dev_i;
  logic [23:0] enc_count_o, cor_target_o;
  logic [31:0] query_data_o;
  logic [4:0] reset_causes_o;
  logic [7:0] cfg_bits_o;
  logic query_valid_o, reset_valid_o, alarm_o, soft_stop_o, hard_stop_o;
  logic power_off_o, reg_en_o, cor_move_o;
  int cnt, err_count, compares, cycles, ns, nh, nm, m, r;
  eda_encoder_alarm #(.TICK_CYCLES(4)) dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .enc_n_i(enc_n_i), .cfg_we_i(cfg_we_i),
    .cfg_bits_i(cfg_bits_i), .cfg_prediv_i(cfg_prediv_i), .cfg_max_dev_i(cfg_max_dev_i),
    .cfg_mult_i(cfg_mult_i), .dev_cfg_we_i(dev_cfg_we_i), .dev_en_i(dev_en_i),
    .dev_stop_i(dev_stop_i), .dev_delay_i(dev_delay_i), .cor_cfg_we_i(cor_cfg_we_i),
    .cor_retries_i(cor_retries_i), .cor_tol_i(cor_tol_i), .reg_cmd_we_i(reg_cmd_we_i),
    .reg_cmd_val_i(reg_cmd_val_i), .pol_we_i(pol_we_i), .pol_ext_i(pol_ext_i),
    .pol_drv_i(pol_drv_i), .ramp_pos_i(ramp_pos_i), .target_pos_i(target_pos_i),
    .ramp_end_i(ramp_end_i), .ext_alarm_i(ext_alarm_i), .drv_err_i(drv_err_i),
    .travel_err_i(travel_err_i), .query_i(query_i), .alarm_reset_i(alarm_reset_i),
    .enc_count_o(enc_count_o), .query_valid_o(query_valid_o), .query_data_o(query_data_o),
    .reset_valid_o(reset_valid_o), .reset_causes_o(reset_causes_o), .alarm_o(alarm_o),
    .soft_stop_o(soft_stop_o), .hard_stop_o(hard_stop_o), .power_off_o(power_off_o),
    .reg_en_o(reg_en_o), .cor_move_o(cor_move_o), .cor_target_o(cor_target_o),
    .cfg_bits_o(cfg_bits_o));
  eda_host_model host_u (.ref_clk_i(ref_clk_i), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i),
    .enc_n_o(enc_n_i), .cfg_we_o(cfg_we_i), .cfg_bits_o(cfg_bits_i),
    .cfg_prediv_o(cfg_prediv_i), .cfg_max_dev_o(cfg_max_dev_i), .cfg_mult_o(cfg_mult_i));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    ns += soft_stop_o === 1'b1;
    nh += hard_stop_o === 1'b1;
    nm += cor_move_o === 1'b1;
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task pl(input int w);
    @(posedge ref_clk_i);
    case (w)
      0: query_i <= 1;
      1: alarm_reset_i <= 1;
      2: dev_cfg_we_i <= 1;
      3: cor_cfg_we_i <= 1;
      4: reg_cmd_we_i <= 1;
      5: pol_we_i <= 1;
      6: ramp_end_i <= 1;
      7: ext_alarm_i <= 1;
      8: drv_err_i <= 1;
      default: travel_err_i <= 1;
    endcase
    @(posedge ref_clk_i);
    {query_i, alarm_reset_i, dev_cfg_we_i, cor_cfg_we_i, reg_cmd_we_i} <= '0;
    {pol_we_i, ramp_end_i, ext_alarm_i, drv_err_i, travel_err_i} <= '0;
    #1;
  endtask
  task report_and_stop;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    r = $urandom(32'hbf85);
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1;
    cyc(3);
    chk(cfg_bits_o, 8'h01);
    chk(alarm_o, 0);
    for (int d = 1; d >= 0; d--) begin
      m = $urandom_range(4, 1);
      host_u.cfg(8'(8'h01 | (d << 6)), 8'd2, 11'h7ff, m[7:0]);
      host_u.step(1, 4);
      cnt += d ? 2 * m : -2 * m;
      cyc(4);
      chk(enc_count_o, cnt[23:0]);
    end
    pl(0);
    chk(query_data_o, {8'h00, cnt[23:0]});
    r = $urandom;
    ramp_pos_i <= r[23:0];
    host_u.cfg(8'h51, 8'd1, 11'h7ff, 8'd1);
    cyc(1);
    chk(enc_count_o, r[23:0]);
    chk(cfg_bits_o[4], 0);
    $display("test encoder done");
    for (int p = 0; p < 2; p++) begin
      host_u.index(!p);
      host_u.cfg(8'(8'h42 | p), 8'd1, 11'h7ff, 8'd1);
      host_u.step(1, 2);
      host_u.index(p);
      host_u.index(!p);
      cyc(4);
      chk(enc_count_o, 0);
    end
    ramp_pos_i <= 0;
    host_u.cfg(8'h41, 8'd1, 11'd5, 8'd1);
    for (int s = 0; s < 3; s++) begin
      {dev_en_i, dev_stop_i, dev_delay_i} <= {1'b1, 2'(s), 16'h0000};
      pl(2);
      {ns, nh} = 0;
      ramp_pos_i <= 5;
      cyc(4);
      chk(alarm_o, 0);
      ramp_pos_i <= 6;
      cyc(4);
      chk(alarm_o, 1);
      chk({ns[15:0], nh[15:0]}, {16'(s == 1), 16'(s == 2)});
      ramp_pos_i <= 0;
      pl(1);
      chk(reset_causes_o, 5'b01000);
      cyc(1);
      chk(alarm_o, 0);
    end
    dev_en_i <= 0;
    pl(2);
    {pol_ext_i, pol_drv_i} <= 2'b11;
    pl(5);
    for (int i = 0; i < 3; i++) begin
      pl(7 + i);
      cyc(1);
      chk(power_off_o, i < 2);
      pl(1);
      chk(reset_causes_o, i == 0 ? 5'b00100 : i == 1 ? 5'b10000 : 5'b00010);
      cyc(1);
      chk({alarm_o, power_off_o}, 0);
    end
    for (int v = 1; v >= 0; v--) begin
      reg_cmd_val_i <= v[0];
      pl(4);
      chk(reg_en_o, v);
    end
    $display("test alarms done");
    {target_pos_i, cor_retries_i, cor_tol_i} <= {24'd3, 8'd2, 16'd3};
    pl(3);
    nm = 0;
    pl(6);
    cyc(4);
    chk(nm, 0);
    target_pos_i <= 10;
    repeat (3) begin
      pl(6);
      cyc(8);
    end
    chk({nm > 0, cor_target_o}, {1'b1, 24'd10});
    chk(alarm_o, 1);
    target_pos_i <= 0;
    pl(1);
    chk(reset_causes_o, 5'b00001);
    {dev_en_i, dev_stop_i, dev_delay_i} <= {1'b1, 2'd0, 16'd2};
    pl(2);
    nm = 0;
    {ramp_pos_i, target_pos_i} <= {24'd6, 24'd10};
    cyc(4);
    chk(nm, 0);
    cyc(16);
    chk(nm, 1);
    chk(alarm_o, 0);
    pl(6);
    cyc(2);
    chk(alarm_o, 1);
    pl(1);
    chk(reset_causes_o, 5'b01001);
    $display("test correction done");
    report_and_stop;
  end
endmodule
